// >>> design/line_event_status_monitor.sv
// line device end: status flags, interrupt gate, ring, hook ramp and tx path
`timescale 1ns/1ps
`include "line_params.svh"
module line_event_status_monitor #(
  parameter int CAL_CYC   = 64,
  parameter int RAMP_FAST = 4,
  parameter int RAMP_MED  = 64,
  parameter int RAMP_SLOW = 256
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  line_link_if.dev         link,
  input  wire logic [15:0] rx_sample,
  input  wire logic [15:0] ring_level,
  input  wire logic        billing_disturb,
  input  wire logic        loop_current_low,
  output logic      [15:0] tx_sample_out,
  output logic             line_offhook,
  output logic             cal_busy,
  output logic             ringer_synth_impedance
);

  // control bits written by the host
  logic [2:0]  mask_reg;
  logic [2:0]  flags_reg;
  logic        hook_request;
  logic        line_monitor_enable;
  logic        ring_level_sel_a;
  logic        ring_level_sel_b;
  logic        hook_ramp_sel_a;
  logic        hook_ramp_sel_b;
  logic        quench_sel_low;
  logic        quench_sel_high;
  logic        global_irq_gate;
  logic        fullwave_ring_sel;
  logic        billing_guard_en;
  logic        resistor_cal_disable;
  logic [3:0]  gain_reg;
  // state shown to the host, plus internal cal and ramp counters
  logic        rx_overload_status;
  logic        billing_event_status;
  logic        loop_dropout_status;
  logic        overload_live;
  logic        ring_pos_detect;
  logic        ring_neg_detect;
  logic [15:0] cal_cnt_reg;
  logic [15:0] ramp_cnt_reg;
  logic [7:0]  rd_mux;

  // ramp length per speed setting
  function automatic logic [15:0] ramp_len_of(input line_pkg::ramp_speed_t s);
    logic [15:0] n;
    n = 16'(RAMP_FAST);
    unique case (s)
      line_pkg::SPEED_FAST: n = 16'(RAMP_FAST);
      line_pkg::SPEED_MED:  n = 16'(RAMP_MED);
      line_pkg::SPEED_SLOW: n = 16'(RAMP_SLOW);
    endcase
    return n;
  endfunction

  // write decode
  wire [7:0] wd        = link.wdata;
  wire       wr_mask   = link.wr && (link.addr == `REG_MASK);
  wire       wr_flags  = link.wr && (link.addr == `REG_FLAGS);
  wire       wr_ctrl   = link.wr && (link.addr == `REG_CTRL);
  wire       wr_cfga   = link.wr && (link.addr == `REG_CFG_A);
  wire       wr_cfgb   = link.wr && (link.addr == `REG_CFG_B);
  wire       wr_cfgc   = link.wr && (link.addr == `REG_CFG_C);
  wire       wr_stat   = link.wr && (link.addr == `REG_STAT);
  wire       wr_cal    = link.wr && (link.addr == `REG_CAL);
  wire       wr_cfgd   = link.wr && (link.addr == `REG_CFG_D);
  wire       wr_gain   = link.wr && (link.addr == `REG_RXGAIN);
  wire       wr_quench = link.wr && (link.addr == `REG_QUENCH);

  // strict peak compare
  // anything at or under the level is treated as a filtered transient
  wire signed [15:0] rx_s     = rx_sample;
  wire signed [15:0] ovl_pos  = `OVL_LEVEL;
  wire signed [15:0] ovl_neg  = 16'h0000 - `OVL_LEVEL;
  wire               ovl_now  = (rx_s > ovl_pos) || (rx_s < ovl_neg);
  wire               btd_ev   = billing_disturb && billing_guard_en;
  wire               dod_ev   = loop_current_low && line_offhook;
  // guard enable write zero clears billing bits
  wire               btd_clr  = wr_stat && !wd[`B_BTE];
  wire [2:0]         ev       = {ovl_now, btd_ev, dod_ev};
  wire [2:0]         clr      = {wr_flags && !wd[`B_ROV], btd_clr, wr_flags && !wd[`B_DOD]};
  // sticky flags, a new event beats a clear in the same cycle
  wire [2:0]         flags_next = ev | (flags_reg & ~clr);

  wire [15:0]        thr      = ring_level_sel_b ? `RING_THR_45V :
                                (ring_level_sel_a ? `RING_THR_15V : `RING_THR_21V);
  wire signed [15:0] ring_s   = ring_level;
  wire signed [15:0] thr_pos  = thr;
  wire signed [15:0] thr_neg  = 16'h0000 - thr;
  // detect bits follow voltage beyond the thresholds
  // a reversal crosses one threshold exactly like a ring half
  wire               pos_now  = ring_s > thr_pos;
  wire               neg_now  = ring_s < thr_neg;
  // half wave reports only positive rings
  wire [15:0]        ring_code = pos_now ? `TX_HIGH :
                                 ((fullwave_ring_sel && !neg_now) ? `TX_MID : `TX_LOW);

  // receive gain or attenuation by shift
  // plain shift keeps the path cheap; no saturation on large gains
  wire [2:0]         sh       = gain_reg[`GAIN_SH_HI:0];
  wire [15:0]        rx_gain  = gain_reg[`B_ATT] ? 16'(rx_s >>> sh) : 16'(rx_s <<< sh);

  // four bits fold into three ramp speeds
  line_pkg::ramp_speed_t spd;
  assign spd = (quench_sel_low && quench_sel_high) ? line_pkg::SPEED_SLOW :
               (hook_ramp_sel_a || hook_ramp_sel_b || quench_sel_low || quench_sel_high) ?
               line_pkg::SPEED_MED : line_pkg::SPEED_FAST;
  wire [15:0]        ramp_len = ramp_len_of(spd);
  // billing disturbance freezes the ramp so the line stays looped
  wire               hold_on  = btd_ev || (ramp_cnt_reg < ramp_len);
  wire               off_next = hook_request || (line_offhook && hold_on);

  // calibration on overload release, or on off-hook entry
  wire               cal_start = (overload_live && !ovl_now) ||
                                 (hook_request && !line_offhook && !resistor_cal_disable);
  wire [15:0]        cal_next  = cal_start ? 16'(CAL_CYC) :
                                 ((cal_cnt_reg != 16'h0000) ? cal_cnt_reg - 16'h0001 : 16'h0000);

  // looped or monitoring sends line data, or mute while calibrating; else ring pattern
  wire [15:0]        tx_next  = (line_offhook || line_monitor_enable) ?
                                (cal_busy ? `TX_MUTE : rx_gain) : ring_code;

  // host writable control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= 3'h0;
      {hook_request, line_monitor_enable, ring_level_sel_a, ring_level_sel_b} <= 4'h0;
      {ringer_synth_impedance, hook_ramp_sel_a, hook_ramp_sel_b} <= 3'h0;
      {quench_sel_low, quench_sel_high, global_irq_gate, fullwave_ring_sel} <= 4'h0;
      {billing_guard_en, resistor_cal_disable} <= 2'h0;
      gain_reg <= 4'h0;
    end else if (ce) begin
      if (wr_mask)
        mask_reg <= {wd[`B_ROV], wd[`B_BTD], wd[`B_DOD]};
      if (wr_ctrl) begin
        hook_request        <= wd[`B_HOOK];
        line_monitor_enable <= wd[`B_MON];
      end
      if (wr_cfga) begin
        ring_level_sel_a       <= wd[`B_RLA];
        ringer_synth_impedance <= wd[`B_RZ];
        hook_ramp_sel_a        <= wd[`B_OHSA];
      end
      if (wr_cfgb)
        ring_level_sel_b <= wd[`B_RLB];
      if (wr_cfgc) begin
        global_irq_gate   <= wd[`B_GATE];
        fullwave_ring_sel <= wd[`B_FULLW];
      end
      if (wr_stat)
        billing_guard_en <= wd[`B_BTE];
      if (wr_cal)
        resistor_cal_disable <= wd[`B_RESISTOR_CAL_DISABLE];
      if (wr_cfgd)
        hook_ramp_sel_b <= wd[`B_OHSB];
      if (wr_gain)
        gain_reg <= wd[`B_ATT:0];
      if (wr_quench) begin
        quench_sel_low  <= wd[`B_SQ0];
        quench_sel_high <= wd[`B_SQ1];
      end
    end
  end

  // event flags and status; set wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= 3'h0;
      {rx_overload_status, billing_event_status, loop_dropout_status} <= 3'h0;
      {overload_live, ring_pos_detect, ring_neg_detect} <= 3'h0;
    end else if (ce) begin
      // overload sets status and flag together
      flags_reg            <= flags_next;
      rx_overload_status   <= ovl_now || (rx_overload_status && !(wr_stat && !wd[`B_ROVS]));
      billing_event_status <= btd_ev || (billing_event_status && !btd_clr);
      loop_dropout_status  <= dod_ev || (loop_dropout_status && !(wr_stat && !wd[`B_DODS]));
      // live bit needs no write to fall
      overload_live        <= ovl_now;
      ring_pos_detect      <= pos_now;
      ring_neg_detect      <= neg_now;
    end
  end

  // hook ramp, calibration and tx sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_offhook  <= 1'b0;
      ramp_cnt_reg  <= 16'h0000;
      cal_cnt_reg   <= 16'h0000;
      cal_busy      <= 1'b0;
      tx_sample_out <= `TX_MUTE;
    end else if (ce) begin
      line_offhook  <= off_next;
      ramp_cnt_reg  <= (hook_request || !line_offhook) ? 16'h0000 :
                       (btd_ev ? ramp_cnt_reg : ramp_cnt_reg + 16'h0001);
      cal_cnt_reg   <= cal_next;
      cal_busy      <= cal_next != 16'h0000;
      tx_sample_out <= tx_next;
    end
  end

  // register readback; unmapped indices read zero
  always_comb begin
    rd_mux = 8'h00;
    case (link.addr)
      `REG_MASK: begin
        rd_mux[`B_ROV] = mask_reg[2];
        rd_mux[`B_BTD] = mask_reg[1];
        rd_mux[`B_DOD] = mask_reg[0];
      end
      `REG_FLAGS: begin
        rd_mux[`B_ROV] = flags_reg[2];
        rd_mux[`B_BTD] = flags_reg[1];
        rd_mux[`B_DOD] = flags_reg[0];
      end
      `REG_CTRL: begin
        rd_mux[`B_HOOK] = hook_request;
        rd_mux[`B_MON]  = line_monitor_enable;
        rd_mux[`B_RPOS] = ring_pos_detect;
        rd_mux[`B_RNEG] = ring_neg_detect;
      end
      `REG_CFG_A: begin
        rd_mux[`B_RLA]  = ring_level_sel_a;
        rd_mux[`B_RZ]   = ringer_synth_impedance;
        rd_mux[`B_OHSA] = hook_ramp_sel_a;
      end
      `REG_CFG_B: rd_mux[`B_RLB] = ring_level_sel_b;
      `REG_CFG_C: begin
        rd_mux[`B_GATE]  = global_irq_gate;
        rd_mux[`B_FULLW] = fullwave_ring_sel;
      end
      `REG_STAT: begin
        rd_mux[`B_OVL]  = overload_live;
        rd_mux[`B_ROVS] = rx_overload_status;
        rd_mux[`B_BTDS] = billing_event_status;
        rd_mux[`B_BTE]  = billing_guard_en;
        rd_mux[`B_DODS] = loop_dropout_status;
      end
      `REG_CAL:    rd_mux[`B_RESISTOR_CAL_DISABLE] = resistor_cal_disable;
      `REG_CFG_D:  rd_mux[`B_OHSB] = hook_ramp_sel_b;
      `REG_RXGAIN: rd_mux[`B_ATT:0] = gain_reg;
      `REG_QUENCH: begin
        rd_mux[`B_SQ0] = quench_sel_low;
        rd_mux[`B_SQ1] = quench_sel_high;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  // link answer and interrupt line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.rdata  <= 8'h00;
      link.rvalid <= 1'b0;
      link.irq    <= 1'b0;
    end else if (ce) begin
      link.rvalid <= link.rd;
      if (link.rd)
        link.rdata <= rd_mux;
      // gated OR of masked pending flags
      link.irq <= global_irq_gate && |(flags_reg & mask_reg);
    end
  end

endmodule

// >>> design/line_host_ctrl.sv
// host end: apb command registers driving the line link, dialing and caller id capture
`timescale 1ns/1ps
`include "line_params.svh"
module line_host_ctrl #(
  parameter int BREAK_CYC = `PULSE_BREAK_MS * 1000 * `CLK_MHZ,
  parameter int MAKE_CYC  = `PULSE_MAKE_MS * 1000 * `CLK_MHZ,
  parameter int REV_CYC   = `REV_WAIT_MS * 1000 * `CLK_MHZ,
  parameter int QUIET_CYC = `RING_QUIET_MS * 1000 * `CLK_MHZ,
  parameter int TW        = 26
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  line_link_if.host        link
);

  line_pkg::host_state_t state_reg;
  logic [TW-1:0] tmr_reg;
  logic [3:0]    cnt_reg;
  logic [7:0]    ctrl_sh;
  logic [7:0]    last_rd;
  logic          seen_reg;
  logic          prev_reg;
  logic          rev_reg;
  logic          ring_flag;
  logic          irq_reg;

  // copy of a byte with one bit forced
  function automatic logic [7:0] setb(input logic [7:0] v, input int pos, input logic b);
    logic [7:0] r;
    r      = v;
    r[pos] = b;
    return r;
  endfunction

  // apb decode; zero wait, answer in the first access cycle
  wire        setup    = psel && !penable;
  wire        acc      = psel && penable && pready;
  wire        busy     = state_reg != line_pkg::H_IDLE;
  wire        cmd_wr   = acc && pwrite;
  wire        wr_link  = cmd_wr && (paddr == `HREG_LINK);
  wire        wr_dial  = cmd_wr && (paddr == `HREG_DIAL) && (pwdata[`DIAL_HI:0] != 4'h0);
  wire        wr_cid   = cmd_wr && (paddr == `HREG_CID);
  wire        cid_stop = wr_cid && pwdata[`CID_STOP];
  wire        ring_now = link.rdata[`B_RPOS] || link.rdata[`B_RNEG];
  wire [31:0] result   = {20'h00000, ring_flag, ctrl_sh[`B_MON], irq_reg, busy, last_rd};

  // apb answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= setup;
      prdata  <= (setup && !pwrite && paddr == `HREG_RESULT) ? result : 32'h00000000;
      // writes to any register but the caller id one are refused while busy
      pslverr <= setup && pwrite && busy && (paddr != `HREG_CID);
    end
  end

  // command sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= line_pkg::H_IDLE;
      tmr_reg    <= '0;
      cnt_reg    <= 4'h0;
      ctrl_sh    <= 8'h00;
      last_rd    <= 8'h00;
      {seen_reg, prev_reg, rev_reg, ring_flag, irq_reg} <= 5'h00;
      link.addr  <= 6'h00;
      link.wdata <= 8'h00;
      link.wr    <= 1'b0;
      link.rd    <= 1'b0;
    end else if (ce) begin
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      irq_reg <= link.irq;
      tmr_reg <= tmr_reg + 1'b1;
      if (cid_stop) begin
        // monitor off once caller id is in
        ctrl_sh    <= setb(ctrl_sh, `B_MON, 1'b0);
        link.wr    <= 1'b1;
        link.addr  <= `REG_CTRL;
        link.wdata <= setb(ctrl_sh, `B_MON, 1'b0);
        state_reg  <= line_pkg::H_IDLE;
      end else begin
        unique case (state_reg)
          line_pkg::H_IDLE: begin
            if (wr_link) begin
              link.addr  <= pwdata[`LK_ADDR_HI:0];
              link.wdata <= pwdata[`LK_DATA_HI:`LK_DATA_LO];
              if (pwdata[`LK_READ]) begin
                link.rd   <= 1'b1;
                state_reg <= line_pkg::H_RD_WAIT;
              end else begin
                link.wr <= 1'b1;
                if (pwdata[`LK_ADDR_HI:0] == `REG_CTRL)
                  ctrl_sh <= pwdata[`LK_DATA_HI:`LK_DATA_LO];
              end
            end else if (wr_dial) begin
              link.wr    <= 1'b1;
              link.addr  <= `REG_CAL;
              link.wdata <= setb(8'h00, `B_RESISTOR_CAL_DISABLE, 1'b1);
              cnt_reg    <= pwdata[`DIAL_HI:0];
              tmr_reg    <= '0;
              state_reg  <= line_pkg::H_BRK;
            end else if (wr_cid && (pwdata[`CID_TYPE1] || pwdata[`CID_REV])) begin
              seen_reg  <= 1'b0;
              ring_flag <= 1'b0;
              rev_reg   <= pwdata[`CID_REV];
              state_reg <= line_pkg::H_POLL;
              if (pwdata[`CID_REV]) begin
                // full wave needed to tell reversal from ring
                link.wr    <= 1'b1;
                link.addr  <= `REG_CFG_C;
                link.wdata <= setb(8'h00, `B_FULLW, 1'b1);
              end
            end
          end
          line_pkg::H_RD_WAIT: begin
            if (link.rvalid) begin
              last_rd   <= link.rdata;
              state_reg <= line_pkg::H_IDLE;
            end
          end
          // break then make, one pulse per period
          line_pkg::H_BRK: begin
            if (tmr_reg == '0) begin
              ctrl_sh    <= setb(ctrl_sh, `B_HOOK, 1'b0);
              link.wr    <= 1'b1;
              link.addr  <= `REG_CTRL;
              link.wdata <= setb(ctrl_sh, `B_HOOK, 1'b0);
            end
            if (tmr_reg == TW'(BREAK_CYC - 1)) begin
              tmr_reg   <= '0;
              state_reg <= line_pkg::H_MAKE;
            end
          end
          line_pkg::H_MAKE: begin
            if (tmr_reg == '0) begin
              ctrl_sh    <= setb(ctrl_sh, `B_HOOK, 1'b1);
              link.wr    <= 1'b1;
              link.addr  <= `REG_CTRL;
              link.wdata <= setb(ctrl_sh, `B_HOOK, 1'b1);
            end
            if (tmr_reg == TW'(MAKE_CYC - 1)) begin
              tmr_reg   <= '0;
              cnt_reg   <= cnt_reg - 4'h1;
              state_reg <= (cnt_reg == 4'h1) ? line_pkg::H_IDLE : line_pkg::H_BRK;
            end
          end
          line_pkg::H_POLL: begin
            link.rd   <= 1'b1;
            link.addr <= `REG_CTRL;
            state_reg <= line_pkg::H_CID_WAIT;
          end
          line_pkg::H_CID_WAIT: begin
            if (link.rvalid) begin
              state_reg <= line_pkg::H_POLL;
              if (!seen_reg) begin
                seen_reg <= ring_now;
                prev_reg <= ring_now;
                tmr_reg  <= '0;
              end else if (rev_reg) begin
                // another edge inside the wait means ring
                if (ring_now != prev_reg) begin
                  rev_reg   <= 1'b0;
                  ring_flag <= 1'b1;
                  tmr_reg   <= '0;
                end else if (tmr_reg >= TW'(REV_CYC)) begin
                  ctrl_sh    <= setb(ctrl_sh, `B_MON, 1'b1);
                  link.wr    <= 1'b1;
                  link.addr  <= `REG_CTRL;
                  link.wdata <= setb(ctrl_sh, `B_MON, 1'b1);
                  state_reg  <= line_pkg::H_IDLE;
                end
              end else if (ring_now) begin
                tmr_reg <= '0;
              end else if (tmr_reg >= TW'(QUIET_CYC)) begin
                ctrl_sh    <= setb(ctrl_sh, `B_MON, 1'b1);
                link.wr    <= 1'b1;
                link.addr  <= `REG_CTRL;
                link.wdata <= setb(ctrl_sh, `B_MON, 1'b1);
                state_reg  <= line_pkg::H_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

endmodule

// >>> inc/line_link_if.sv
// register link between host controller and line device
`timescale 1ns/1ps
interface line_link_if;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       rvalid;
  logic       irq;
  modport dev  (input addr, wdata, wr, rd, output rdata, rvalid, irq);
  modport host (output addr, wdata, wr, rd, input rdata, rvalid, irq);
endinterface

// >>> inc/line_params.svh
// constants shared by both ends of the line link
`ifndef LINE_PARAMS_SVH
`define LINE_PARAMS_SVH
// device register indices
`define REG_MASK   6'h03
`define REG_FLAGS  6'h04
`define REG_CTRL   6'h05
`define REG_CFG_A  6'h10
`define REG_CFG_B  6'h11
`define REG_CFG_C  6'h12
`define REG_STAT   6'h13
`define REG_CAL    6'h19
`define REG_CFG_D  6'h1F
`define REG_RXGAIN 6'h27
`define REG_QUENCH 6'h3B
// device bit positions
`define B_HOOK     0
`define B_MON      3
`define B_RPOS     5
`define B_RNEG     6
`define B_DOD      0
`define B_BTD      1
`define B_ROV      2
`define B_RLA      0
`define B_RZ       1
`define B_OHSA     6
`define B_RLB      4
`define B_GATE     0
`define B_FULLW    1
`define B_OVL      0
`define B_ROVS     1
`define B_BTDS     2
`define B_BTE      3
`define B_DODS     4
`define B_RESISTOR_CAL_DISABLE    5
`define B_OHSB     3
`define B_SQ0      0
`define B_SQ1      1
`define B_ATT      3
`define GAIN_SH_HI 2
// levels: rx samples in mV, ring level in 10 mV steps
`define OVL_LEVEL    16'h044C
`define RING_THR_15V 16'h05DC
`define RING_THR_21V 16'h0834
`define RING_THR_45V 16'h1194
`define TX_HIGH      16'h7FFF
`define TX_LOW       16'h8000
`define TX_MID       16'h04CC
`define TX_MUTE      16'h0000
// host timing
`define CLK_MHZ        250
`define PULSE_BREAK_MS 60
`define PULSE_MAKE_MS  40
`define REV_WAIT_MS    40
`define RING_QUIET_MS  200
// host apb map and fields
`define HREG_LINK   12'h000
`define HREG_RESULT 12'h004
`define HREG_DIAL   12'h008
`define HREG_CID    12'h00C
`define LK_ADDR_HI  5
`define LK_DATA_LO  8
`define LK_DATA_HI  15
`define LK_READ     16
`define DIAL_HI     3
`define CID_TYPE1   0
`define CID_REV     1
`define CID_STOP    2
`endif

// >>> inc/line_pkg.sv
// types shared by both ends of the line link
package line_pkg;
  typedef enum logic [1:0] {SPEED_FAST, SPEED_MED, SPEED_SLOW} ramp_speed_t;
  typedef enum logic [2:0] {H_IDLE, H_RD_WAIT, H_BRK, H_MAKE, H_POLL, H_CID_WAIT} host_state_t;
endpackage

// >>> tb/line_event_status_monitor_bench.sv
// bench: host and line ends joined over the link, apb stimulus
`timescale 1ns/1ps
module line_event_status_monitor_bench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        billing_disturb = 1'b0, loop_current_low = 1'b0, pready, e, ce = 1'b1, offh, calb, rz;
  logic [11:0] paddr = 12'h000;
  logic [15:0] rx_sample = 16'h0000, v, ring = 16'h0000, txo;
  logic [31:0] pwdata = 32'h00000000, prdata, rv, seed = 32'h00011EAF;
  int          fail_count = 0, total_checks = 0;
  line_link_if link ();
  line_host_ctrl #(.BREAK_CYC(20), .MAKE_CYC(20), .REV_CYC(30), .QUIET_CYC(40)) u_line_host_ctrl (
    .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .link(link));
  line_event_status_monitor u_line_event_status_monitor (.pclk(pclk), .presetn(presetn), .ce(ce),
    .link(link), .rx_sample(rx_sample), .ring_level(ring), .billing_disturb(billing_disturb),
    .loop_current_low(loop_current_low), .tx_sample_out(txo), .line_offhook(offh), .cal_busy(calb),
    .ringer_synth_impedance(rz));
  line_event_status_monitor_chk u_line_event_status_monitor_chk (.pclk(pclk), .presetn(presetn),
    .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
    .rvalid(link.rvalid), .irq(link.irq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // strict magnitude compare, so exactly 1100 mV stays quiet
  function automatic logic exp_ovl(input logic [15:0] x);
    return $signed(x) > $signed(16'h044C) || $signed(x) < -$signed(16'h044C);
  endfunction
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, g, x);
    end
  endtask
  // one apb transfer; slave latency is not assumed, the wait is bounded
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail_count++;
      end_of_test();
    end
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic lw(input logic [5:0] i, input logic [7:0] d);
    apb(1'b1, 12'h000, {16'h0000, d, 2'b00, i});
  endtask
  // link read, then poll the result word until the host is idle
  task automatic lr(input logic [5:0] i);
    int n;
    apb(1'b1, 12'h000, {15'h0000, 1'b1, 8'h00, 2'b00, i});
    for (n = 0; n < 20; n++) begin
      apb(1'b0, 12'h004, 32'h00000000);
      if (rv[8] === 1'b0) break;
    end
  endtask
  initial forever #2 pclk = ~pclk;
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    end_of_test();
  end
  initial begin
    e = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    lw(6'h03, 8'h07);
    lr(6'h03);
    chk(rv[7:0], 8'h07);
    chk(txo, 16'h8000);
    lw(6'h10, 8'h02);
    ring <= 16'h0900;
    lr(6'h05);
    chk(rz, 1'b1);
    chk(rv[6:5], 2'h1);
    chk(txo, 16'h7FFF);
    // the same level sits below the highest threshold
    lw(6'h11, 8'h10);
    lr(6'h05);
    chk(rv[6:5], 2'h0);
    lw(6'h11, 8'h00);
    ring <= 16'hF700;
    lw(6'h12, 8'h03);
    lr(6'h05);
    chk(rv[6:5], 2'h2);
    chk(txo, 16'h8000);
    ring <= 16'h0000;
    rx_sample <= 16'hFBB4;
    repeat (40) begin
      @(posedge pclk);
      seed = xs(seed);
      v = seed[15:0] % 16'h0899 - 16'h044C;
      e = e | exp_ovl(v);
      rx_sample <= v;
    end
    lr(6'h04);
    chk(rv[2], e);
    chk(txo, 16'h04CC);
    rx_sample <= 16'h044D;
    @(posedge pclk);
    rx_sample <= 16'h0000;
    lr(6'h13);
    chk(rv[4:0], 5'h02);
    chk(calb, 1'b1);
    lr(6'h04);
    chk(rv[2], 1'b1);
    chk(rv[9], 1'b1);
    lw(6'h04, 8'h03);
    lr(6'h04);
    chk(rv[9:0], 10'h000);
    // loop current only exists while off-hook, so go off-hook first
    lw(6'h05, 8'h01);
    repeat (3) @(posedge pclk);
    chk(offh, 1'b1);
    chk(calb, 1'b1);
    chk(txo, 16'h0000);
    loop_current_low <= 1'b1;
    @(posedge pclk);
    loop_current_low <= 1'b0;
    lr(6'h04);
    chk(rv[2:0], 3'h1);
    chk(rv[9], 1'b1);
    lw(6'h13, 8'h08);
    billing_disturb <= 1'b1;
    @(posedge pclk);
    billing_disturb <= 1'b0;
    lr(6'h13);
    chk(rv[3:2], 2'h3);
    lw(6'h13, 8'h00);
    lr(6'h13);
    chk(rv[3:2], 2'h0);
    lw(6'h03, 8'h00);
    lr(6'h20);
    chk(rv[9:0], 10'h000);
    // an overload while frozen must leave no trace
    ce <= 1'b0;
    rx_sample <= 16'h0800;
    repeat (3) @(posedge pclk);
    ce <= 1'b1;
    rx_sample <= 16'h0000;
    lr(6'h13);
    chk(rv[1:0], 2'h0);
    lw(6'h27, 8'h01);
    rx_sample <= 16'h0100;
    repeat (64) @(posedge pclk);
    chk(txo, 16'h0200);
    // fast ramp keeps the loop a few cycles after the hook clears
    lw(6'h05, 8'h00);
    chk(offh, 1'b1);
    repeat (8) @(posedge pclk);
    chk(offh, 1'b0);
    lw(6'h12, 8'h00);
    end_of_test();
  end
endmodule

// >>> tb/line_event_status_monitor_chk.sv
// link checker: read answers and interrupt gating on the wires
`timescale 1ns/1ps
module line_event_status_monitor_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic       irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] mask_seen;
  // low three bits of the last mask write on the link; the readback must match them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mask_seen <= 3'h0;
    else if (wr && addr == 6'h03)
      mask_seen <= wdata[2:0];
  end
  sequence s_mask_rd; rd && addr == 6'h03; endsequence
  a_read_answer: assert property (rd |=> rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (rvalid |-> $past(rd))
    else $error("answer without read");
  a_rdata_hold: assert property (!rvalid |-> $stable(rdata))
    else $error("read byte moved");
  a_unmapped_zero: assert property (rd && addr == 6'h20 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_mask_back: assert property (s_mask_rd |=> rdata[2:0] == $past(mask_seen))
    else $error("mask readback wrong");
  a_mask_off: assert property (wr && addr == 6'h03 && wdata == 8'h00 |-> ##3 !irq)
    else $error("irq with all masks off");
  a_gate_off: assert property (wr && addr == 6'h12 && !wdata[0] |-> ##3 !irq)
    else $error("irq with gate off");
  // irq only drops after a clearing, masking or gating write
  a_irq_fall: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("irq fell on its own");
endmodule
